/* design/cssch_map.svh */
// register offsets, field positions, reset values and timing figures
// assumes inclusion by the scheduler package users; definitions only
`ifndef CSSCH_MAP_SVH
`define CSSCH_MAP_SVH

// register byte offsets on the apb slave
`define CSSCH_REG_MODE 8'h00
`define CSSCH_REG_SLEEP_PERIOD 8'h04
`define CSSCH_REG_SLEEP_COUNT 8'h08
`define CSSCH_REG_AWAKE_TIME 8'h0C
`define CSSCH_REG_SAMPLE_INTERVAL 8'h10
`define CSSCH_REG_LINE_FUNC 8'h14
`define CSSCH_REG_COMMAND 8'h18
`define CSSCH_REG_STATUS 8'h1C

// mode register fields
`define CSSCH_MODE_SEL_LSB 0
`define CSSCH_MODE_SEL_MSB 2
`define CSSCH_MODE_OPT_LSB 8
`define CSSCH_MODE_OPT_MSB 15
`define CSSCH_SEL_CYCLIC 3'h4
`define CSSCH_SEL_CYCLIC_PIN 3'h5
`define CSSCH_OPT_EXT_BIT 2
`define CSSCH_OPT_STAY_BIT 1

// command register: force sleep strobe
`define CSSCH_CMD_FORCE_SLEEP 0

// status register fields
`define CSSCH_STAT_STATE_LSB 0
`define CSSCH_STAT_STATE_MSB 1
`define CSSCH_STAT_AWAKE_BIT 2
`define CSSCH_STAT_PER_LSB 16
`define CSSCH_STAT_PER_MSB 31

// line function codes
`define CSSCH_FUNC_W 4
`define CSSCH_FUNC_DISABLED 4'h0
`define CSSCH_FUNC_ANALOG 4'h2
`define CSSCH_FUNC_DIG_IN 4'h3

// special sample interval: one sample right after waking
`define CSSCH_INTERVAL_SINGLE 16'h0800

// reset values
`define CSSCH_RST_MODE 3'h0
`define CSSCH_RST_OPTION 8'h00
`define CSSCH_RST_SLEEP_PERIOD 16'h0064
`define CSSCH_RST_SLEEP_COUNT 16'h0001
`define CSSCH_RST_AWAKE_TIME 16'h0064
`define CSSCH_RST_INTERVAL 16'h0000

// timing: clock period and time units in ns, 10 ms built from 1 ms ticks
`define CSSCH_CLK_NS 4
`define CSSCH_MS_NS 1000000
`define CSSCH_TENS_PER_UNIT 10

`endif

/* design/cssch_pkg.sv */
// types shared by the cyclic sleep scheduler files
// assumes nothing beyond a systemverilog compiler
package cssch_pkg;

  // scheduler states
  typedef enum logic [1:0] {
    CSSCH_IDLE = 2'b00,
    CSSCH_SLEEP = 2'b01,
    CSSCH_AWAKE = 2'b10
  } cssch_state_t;

  // software configuration travelling as one bundle
  typedef struct packed {
    logic [2:0] mode;
    logic [7:0] option;
    logic [15:0] sleep_period;
    logic [15:0] sleep_period_count;
    logic [15:0] awake_time;
    logic [15:0] sample_interval;
  } cssch_cfg_t;

endpackage

/* design/cssch_tick.sv */
// enable pulse divider: one-cycle tick every div enabled cycles
// assumes a single clock and an asynchronous active-high reset
`timescale 1ns/100ps
module cssch_tick #(
  parameter int WIDTH = 18
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic en,
  input wire logic clr,
  input wire logic [WIDTH-1:0] div,
  // result
  output logic tick
);

  logic [WIDTH-1:0] cnt;
  wire logic [WIDTH-1:0] div_m1;
  wire logic at_end;

  // a zero divisor behaves as one, so the tick never stalls
  assign div_m1 = (div == '0) ? '0 : div - WIDTH'(1);
  assign at_end = en && (cnt >= div_m1);

  // clear realigns the phase so a new window starts a full unit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (clr) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= at_end;
      if (at_end) begin
        cnt <= '0;
      end else if (en) begin
        cnt <= cnt + WIDTH'(1);
      end
    end
  end

endmodule // cssch_tick

/* design/cssch_top.sv */
// cyclic sleep and sample scheduler with apb register access
// assumes apb master on CLOCK, inputs synchronous to CLOCK
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "cssch_map.svh"

module cssch_top #(
  parameter int NLINES = 8,
  parameter int MS_CYCLES = `CSSCH_MS_NS / `CSSCH_CLK_NS
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // wake sources
  input wire logic PIN_WAKE,
  input wire logic RADIO_DATA,
  // node outputs
  output logic AWAKE_INDICATOR,
  output logic SAMPLE_STROBE,
  output logic [NLINES-1:0] SAMPLE_DIG_MASK,
  output logic [NLINES-1:0] SAMPLE_ANA_MASK
);

  localparam int FW = `CSSCH_FUNC_W;

  cssch_pkg::cssch_cfg_t cfg;
  logic [NLINES*FW-1:0] line_function;
  cssch_pkg::cssch_state_t state;
  cssch_pkg::cssch_state_t next_state;
  logic [15:0] slp_cnt;
  logic [15:0] next_slp_cnt;
  logic [15:0] per_cnt;
  logic [15:0] next_per_cnt;
  logic [15:0] awk_cnt;
  logic [15:0] next_awk_cnt;
  logic [15:0] smp_cnt;
  logic [15:0] next_smp_cnt;
  logic next_strobe;
  logic restart;
  logic enter_awake;
  logic ms_tick;
  logic tens_tick;
  logic [NLINES-1:0] dig_en;
  logic [NLINES-1:0] ana_en;

  // apb decode
  wire logic setup = PSEL && !PENABLE;
  wire logic wr = PSEL && PENABLE && PREADY && PWRITE;
  wire logic sel_mode = (PADDR == `CSSCH_REG_MODE);
  wire logic sel_per = (PADDR == `CSSCH_REG_SLEEP_PERIOD);
  wire logic sel_cnt = (PADDR == `CSSCH_REG_SLEEP_COUNT);
  wire logic sel_awk = (PADDR == `CSSCH_REG_AWAKE_TIME);
  wire logic sel_int = (PADDR == `CSSCH_REG_SAMPLE_INTERVAL);
  wire logic sel_line = (PADDR == `CSSCH_REG_LINE_FUNC);
  wire logic sel_cmd = (PADDR == `CSSCH_REG_COMMAND);
  wire logic sel_stat = (PADDR == `CSSCH_REG_STATUS);
  wire logic hit = sel_mode | sel_per | sel_cnt | sel_awk | sel_int | sel_line |
                   sel_cmd | sel_stat;
  wire logic force_sleep = wr && sel_cmd && PWDATA[`CSSCH_CMD_FORCE_SLEEP];

  // status word shows the scheduler's own state
  wire logic [31:0] status_word = {per_cnt, 13'h0000, (state != cssch_pkg::CSSCH_SLEEP),
                                   state};

  // read selection; the command register reads as zero
  wire logic [31:0] rd_mux =
    sel_mode ? {16'h0000, cfg.option, 5'h00, cfg.mode} :
    sel_per ? {16'h0000, cfg.sleep_period} :
    sel_cnt ? {16'h0000, cfg.sleep_period_count} :
    sel_awk ? {16'h0000, cfg.awake_time} :
    sel_int ? {16'h0000, cfg.sample_interval} :
    sel_line ? 32'(line_function) :
    sel_stat ? status_word : 32'h0000_0000;

  // zero-wait answer: ready and data are registered in the setup cycle
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && !hit;
      if (setup) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // configuration registers, written at the access edge
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      cfg.mode <= `CSSCH_RST_MODE;
      cfg.option <= `CSSCH_RST_OPTION;
      cfg.sleep_period <= `CSSCH_RST_SLEEP_PERIOD;
      cfg.sleep_period_count <= `CSSCH_RST_SLEEP_COUNT;
      cfg.awake_time <= `CSSCH_RST_AWAKE_TIME;
      cfg.sample_interval <= `CSSCH_RST_INTERVAL;
      line_function <= '0;
    end else if (wr) begin
      if (sel_mode) begin
        cfg.mode <= PWDATA[`CSSCH_MODE_SEL_MSB:`CSSCH_MODE_SEL_LSB];
        cfg.option <= PWDATA[`CSSCH_MODE_OPT_MSB:`CSSCH_MODE_OPT_LSB];
      end
      if (sel_per) begin
        cfg.sleep_period <= PWDATA[15:0];
      end
      if (sel_cnt) begin
        cfg.sleep_period_count <= PWDATA[15:0];
      end
      if (sel_awk) begin
        cfg.awake_time <= PWDATA[15:0];
      end
      if (sel_int) begin
        cfg.sample_interval <= PWDATA[15:0];
      end
      if (sel_line) begin
        line_function <= PWDATA[NLINES*FW-1:0];
      end
    end
  end

  // per-line sampling enables
  genvar gi;
  generate
    for (gi = 0; gi < NLINES; gi++) begin : g_line
      wire logic [FW-1:0] fn = line_function[gi*FW +: FW];
      assign dig_en[gi] = (fn == `CSSCH_FUNC_DIG_IN);
      assign ana_en[gi] = (fn == `CSSCH_FUNC_ANALOG);
    end
  endgenerate

  // mode decode
  wire logic any_en = |{dig_en, ana_en};
  wire logic cyclic = (cfg.mode == `CSSCH_SEL_CYCLIC) ||
                      (cfg.mode == `CSSCH_SEL_CYCLIC_PIN);
  wire logic pin_wake = (cfg.mode == `CSSCH_SEL_CYCLIC_PIN) && PIN_WAKE;
  wire logic ext = cfg.option[`CSSCH_OPT_EXT_BIT];
  wire logic stay_full = cfg.option[`CSSCH_OPT_STAY_BIT];
  wire logic single = (cfg.sample_interval == `CSSCH_INTERVAL_SINGLE);
  wire logic periodic = !single && (cfg.sample_interval != 16'h0000);

  // unit ends, compared one wider so a full-scale setting cannot wrap
  wire logic period_done = tens_tick &&
    ({1'b0, slp_cnt} + 17'h0_0001 >= {1'b0, cfg.sleep_period});
  wire logic more_periods = ext &&
    ({1'b0, per_cnt} + 17'h0_0001 < {1'b0, cfg.sleep_period_count});
  wire logic awake_done = (ext && !stay_full) ||
    ({1'b0, awk_cnt} + 17'h0_0001 >= {1'b0, cfg.awake_time});
  wire logic sample_due = periodic &&
    ({1'b0, smp_cnt} + 17'h0_0001 >= {1'b0, cfg.sample_interval});

  // 1 ms enable from the clock, 10 ms enable from ten of those
  cssch_tick #(.WIDTH(18)) u_ms (
    .clk(CLOCK),
    .rst(RESET),
    .en(1'b1),
    .clr(restart),
    .div(18'(MS_CYCLES)),
    .tick(ms_tick)
  );

  cssch_tick #(.WIDTH(4)) u_tens (
    .clk(CLOCK),
    .rst(RESET),
    .en(ms_tick),
    .clr(restart),
    .div(4'(`CSSCH_TENS_PER_UNIT)),
    .tick(tens_tick)
  );

  // scheduler next state
  always_comb begin
    next_state = state;
    next_slp_cnt = slp_cnt;
    next_per_cnt = per_cnt;
    next_awk_cnt = awk_cnt;
    next_smp_cnt = smp_cnt;
    next_strobe = 1'b0;
    restart = 1'b0;
    enter_awake = 1'b0;
    unique case (state)
      cssch_pkg::CSSCH_IDLE: begin
        if (cyclic) begin
          enter_awake = 1'b1;
        end
      end
      cssch_pkg::CSSCH_SLEEP: begin
        if (!cyclic) begin
          next_state = cssch_pkg::CSSCH_IDLE;
        end else if (pin_wake || (ext && RADIO_DATA)) begin
          enter_awake = 1'b1;
        end else if (period_done && more_periods) begin
          next_slp_cnt = 16'h0000;
          next_per_cnt = per_cnt + 16'h0001;
        end else if (period_done) begin
          enter_awake = 1'b1;
        end else if (tens_tick) begin
          next_slp_cnt = slp_cnt + 16'h0001;
        end
      end
      cssch_pkg::CSSCH_AWAKE: begin
        if (!cyclic) begin
          next_state = cssch_pkg::CSSCH_IDLE;
        end else if (force_sleep || (ms_tick && awake_done)) begin
          next_state = cssch_pkg::CSSCH_SLEEP;
          restart = 1'b1;
          next_slp_cnt = 16'h0000;
          next_per_cnt = 16'h0000;
        end else if (ms_tick) begin
          next_awk_cnt = awk_cnt + 16'h0001;
          if (sample_due) begin
            next_strobe = any_en;
            next_smp_cnt = 16'h0000;
          end else begin
            next_smp_cnt = smp_cnt + 16'h0001;
          end
        end
      end
    endcase
    // every wake starts fresh windows and may fire the single sample
    if (enter_awake) begin
      next_state = cssch_pkg::CSSCH_AWAKE;
      restart = 1'b1;
      next_slp_cnt = 16'h0000;
      next_per_cnt = 16'h0000;
      next_awk_cnt = 16'h0000;
      next_smp_cnt = 16'h0000;
      next_strobe = single && any_en;
    end
  end

  // scheduler state and counters
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      state <= cssch_pkg::CSSCH_IDLE;
      slp_cnt <= 16'h0000;
      per_cnt <= 16'h0000;
      awk_cnt <= 16'h0000;
      smp_cnt <= 16'h0000;
    end else begin
      state <= next_state;
      slp_cnt <= next_slp_cnt;
      per_cnt <= next_per_cnt;
      awk_cnt <= next_awk_cnt;
      smp_cnt <= next_smp_cnt;
    end
  end

  // registered node outputs; indicator follows the next state so it
  // rises together with the wake and the single sample
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      AWAKE_INDICATOR <= 1'b0;
      SAMPLE_STROBE <= 1'b0;
      SAMPLE_DIG_MASK <= '0;
      SAMPLE_ANA_MASK <= '0;
    end else begin
      AWAKE_INDICATOR <= (next_state != cssch_pkg::CSSCH_SLEEP);
      SAMPLE_STROBE <= next_strobe;
      SAMPLE_DIG_MASK <= dig_en;
      SAMPLE_ANA_MASK <= ana_en;
    end
  end

endmodule // cssch_top

/* tb/cssch_checker.sv */
// concurrent checks on the scheduler's apb and node outputs
// assumes a bind onto cssch_top; sees only its ports
`timescale 1ns/100ps
`include "cssch_map.svh"
module cssch_checker #(
  parameter int NLINES = 8
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  // wake sources
  input wire logic PIN_WAKE,
  input wire logic RADIO_DATA,
  // node outputs
  input wire logic AWAKE_INDICATOR,
  input wire logic SAMPLE_STROBE,
  input wire logic [NLINES-1:0] SAMPLE_DIG_MASK,
  input wire logic [NLINES-1:0] SAMPLE_ANA_MASK
);
  logic [3:0] line1_func;
  // access decode
  wire acc = PSEL && PENABLE && PREADY;
  wire wr_lf = acc && PWRITE && PADDR == `CSSCH_REG_LINE_FUNC;
  // last line1 function written, kept to judge the masks
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET)
      line1_func <= 4'h0;
    else if (wr_lf)
      line1_func <= PWDATA[7:4];
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_force;
    acc && PWRITE && PADDR == `CSSCH_REG_COMMAND && PWDATA[0] && AWAKE_INDICATOR;
  endsequence
  AST_READY: assert property (s_setup |=> PREADY)
    else $error("no ready after setup");
  AST_UNMAPPED: assert property (s_setup and PADDR > 8'h1C |=> PSLVERR)
    else $error("no error on unmapped access");
  AST_FORCE: assert property (s_force |-> ##[1:2] !AWAKE_INDICATOR)
    else $error("force sleep not taken");
  AST_STROBE_PULSE: assert property (SAMPLE_STROBE |=> !SAMPLE_STROBE)
    else $error("strobe longer than a cycle");
  AST_STROBE_AWAKE: assert property (SAMPLE_STROBE |-> AWAKE_INDICATOR)
    else $error("strobe while asleep");
  AST_NEED_LINE: assert property (SAMPLE_STROBE |-> (|SAMPLE_DIG_MASK) || (|SAMPLE_ANA_MASK))
    else $error("strobe with no line enabled");
  AST_DIG: assert property (wr_lf |-> ##2 SAMPLE_DIG_MASK[1] == (line1_func == 4'h3))
    else $error("digital mask wrong");
  AST_ANA: assert property (wr_lf |-> ##2 SAMPLE_ANA_MASK[1] == (line1_func == 4'h2))
    else $error("analog mask wrong");
endmodule // cssch_checker

bind cssch_top cssch_checker #(.NLINES(NLINES)) cssch_checker_i (
  .CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .PIN_WAKE(PIN_WAKE), .RADIO_DATA(RADIO_DATA), .AWAKE_INDICATOR(AWAKE_INDICATOR),
  .SAMPLE_STROBE(SAMPLE_STROBE), .SAMPLE_DIG_MASK(SAMPLE_DIG_MASK),
  .SAMPLE_ANA_MASK(SAMPLE_ANA_MASK));

/* tb/cssch_node_model.sv */
// parent radio node: raises pin wake or radio data on request
// assumes requests only while the node sleeps; holds until it wakes
`timescale 1ns/100ps
module cssch_node_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench requests and node state
  input wire logic req_pin,
  input wire logic req_radio,
  input wire logic awake,
  // wake sources into the node
  output logic pin_wake,
  output logic radio_data
);
  // held until seen awake, as a parent keeps its data buffered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_wake <= 1'b0;
      radio_data <= 1'b0;
    end else begin
      pin_wake <= req_pin || (pin_wake && !awake);
      radio_data <= req_radio || (radio_data && !awake);
    end
  end
endmodule // cssch_node_model

/* tb/cssch_top_tb.sv */
// self-checking bench for the cyclic sleep scheduler
// assumes 1 ms shortened to 10 cycles through MS_CYCLES
`timescale 1ns/100ps
`include "cssch_map.svh"
module cssch_top_tb;
  logic CLOCK, RESET, PSEL, PENABLE, PWRITE, req_pin, req_radio, err;
  logic PREADY, PSLVERR, PIN_WAKE, RADIO_DATA, AWAKE_INDICATOR, SAMPLE_STROBE;
  logic [7:0] PADDR, SAMPLE_DIG_MASK, SAMPLE_ANA_MASK;
  logic [31:0] PWDATA, PRDATA, rd;
  int num_errors, cmp_count, n, s;

  cssch_top #(.NLINES(8), .MS_CYCLES(10)) cssch_top_i (.CLOCK(CLOCK), .RESET(RESET),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .PIN_WAKE(PIN_WAKE),
    .RADIO_DATA(RADIO_DATA), .AWAKE_INDICATOR(AWAKE_INDICATOR), .SAMPLE_STROBE(SAMPLE_STROBE),
    .SAMPLE_DIG_MASK(SAMPLE_DIG_MASK), .SAMPLE_ANA_MASK(SAMPLE_ANA_MASK));
  cssch_node_model cssch_node_model_i (.clk(CLOCK), .rst(RESET), .req_pin(req_pin),
    .req_radio(req_radio), .awake(AWAKE_INDICATOR), .pin_wake(PIN_WAKE),
    .radio_data(RADIO_DATA));

  // 250 MHz clock
  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end

  task summarize;
    $display("compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task timeout;
    num_errors++;
    $display("ERROR t=%0t wait limit used up", $time);
    summarize;
  endtask

  // every signal moves just after a rising edge; ready and data are taken
  // at the edge that samples ready high, and only then is the bus released
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CLOCK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    if (PREADY !== 1'b1) timeout;
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task cfg(input logic [31:0] md, sp, sn, st, ir, lf);
    apb(1'b1, `CSSCH_REG_MODE, 32'h0000_0000);
    apb(1'b1, `CSSCH_REG_SLEEP_PERIOD, sp);
    apb(1'b1, `CSSCH_REG_SLEEP_COUNT, sn);
    apb(1'b1, `CSSCH_REG_AWAKE_TIME, st);
    apb(1'b1, `CSSCH_REG_SAMPLE_INTERVAL, ir);
    apb(1'b1, `CSSCH_REG_LINE_FUNC, lf);
    apb(1'b1, `CSSCH_REG_MODE, md);
  endtask

  // cycles and strobes while the indicator holds lvl
  task meas(input logic lvl);
    n = 0;
    s = 0;
    while (AWAKE_INDICATOR === lvl && n < 8000) begin
      s += SAMPLE_STROBE;
      n++;
      @(posedge CLOCK);
      #1;
    end
    if (n >= 8000) timeout;
  endtask

  task wait_lvl(input logic lvl);
    @(posedge CLOCK);
    #1;
    meas(!lvl);
  endtask

  task t_regs;
    apb(1'b0, `CSSCH_REG_SLEEP_PERIOD, 32'h0000_0000);
    chk(rd, 32'h0000_0064);
    apb(1'b0, `CSSCH_REG_SLEEP_COUNT, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'b0, `CSSCH_REG_AWAKE_TIME, 32'h0000_0000);
    chk(rd, 32'h0000_0064);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(err, 1'b1);
    apb(1'b0, `CSSCH_REG_MODE, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(err, 1'b0);
    apb(1'b0, `CSSCH_REG_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    apb(1'b1, `CSSCH_REG_SAMPLE_INTERVAL, 32'h0000_0258);
    apb(1'b0, `CSSCH_REG_SAMPLE_INTERVAL, 32'h0000_0000);
    chk(rd, 32'h0000_0258);
    apb(1'b0, `CSSCH_REG_COMMAND, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test regs done");
  endtask

  task t_cyclic(input logic [31:0] lf, input int strobes);
    cfg(32'h0000_0004, 32'h0000_0002, 32'h0000_0001, 32'h0000_0005, 32'h0000_0002, lf);
    wait_lvl(1'b0);
    meas(1'b0);
    chk(n >= 198 && n <= 202, 1'b1);
    meas(1'b1);
    chk(n >= 48 && n <= 52, 1'b1);
    chk(s, strobes);
    $display("test cyclic done");
  endtask

  task t_ext;
    cfg(32'h0000_0604, 32'h0000_0002, 32'h0000_0003, 32'h0000_0005, 32'h0000_0800,
      32'h0000_0030);
    wait_lvl(1'b0);
    meas(1'b0);
    chk(n >= 598 && n <= 602, 1'b1);
    meas(1'b1);
    chk(n >= 48 && n <= 52, 1'b1);
    chk(s, 1);
    $display("test extended done");
  endtask

  task t_force;
    cfg(32'h0000_0004, 32'h0000_0002, 32'h0000_0001, 32'h0000_0064, 32'h0000_0000,
      32'h0000_0030);
    wait_lvl(1'b0);
    meas(1'b0);
    apb(1'b1, `CSSCH_REG_COMMAND, 32'h0000_0001);
    @(posedge CLOCK);
    #1;
    chk(AWAKE_INDICATOR, 1'b0);
    $display("test force done");
  endtask

  // early wake by pin or by radio data; mode 4 must ignore the pin
  task t_wake(input logic [31:0] md, input logic pin, input logic early);
    cfg(md, 32'h0000_0032, 32'h0000_0002, 32'h0000_0005, 32'h0000_0000, 32'h0000_0000);
    wait_lvl(1'b0);
    repeat (20) @(posedge CLOCK);
    req_pin <= pin;
    req_radio <= !pin;
    @(posedge CLOCK);
    req_pin <= 1'b0;
    req_radio <= 1'b0;
    #1;
    meas(1'b0);
    chk(n <= 8, early);
    $display("test wake done");
  endtask

  initial begin
    num_errors = 0;
    cmp_count = 0;
    RESET = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    req_pin = 1'b0;
    req_radio = 1'b0;
    repeat (12) @(posedge CLOCK);
    RESET <= 1'b0;
    t_regs;
    t_cyclic(32'h0000_0030, 2);
    t_cyclic(32'h0000_0000, 0);
    t_cyclic(32'h0000_0020, 2);
    t_ext;
    t_force;
    t_wake(32'h0000_0005, 1'b1, 1'b1);
    t_wake(32'h0000_0404, 1'b0, 1'b1);
    t_wake(32'h0000_0004, 1'b1, 1'b0);
    summarize;
  end
endmodule // cssch_top_tb
